// ==== rtl/param_store_consts.svh ====
// Constants of the parameter store and restore control block.
// Assumes object index and subindex are joined on the register address.
`ifndef PARAM_STORE_CONSTS_SVH
`define PARAM_STORE_CONSTS_SVH
`define CAT_COUNT 7
`define OBJ_STORE 16'h1010
`define OBJ_DISCARD 16'h1011
`define OBJ_MARKER 16'h1020
`define OBJ_REBOOT 16'h2800
`define OBJ_IRQ_STATUS 16'hF000
`define OBJ_IRQ_ENABLE 16'hF001
`define OBJ_IRQ_CLEAR 16'hF002
`define KEY_SAVE 32'h65766173
`define KEY_DISCARD 32'h64616F6C
`define KEY_REBOOT 32'h746F6F62
`define SUB_ALL 8'h01
`define SUB_MARKER_HI 8'h02
`define SUB_TUNING 8'h06
`define SUB_BUS 8'h0B
`define CAT_TUNING_IDX 5
`define MASK_ALL 7'h5F
`define SAVE_DONE_VALUE 32'h00000001
`define ENTRY_RESET 32'h00000000
`define IRQ_SAVE_DONE 0
`define IRQ_DISCARD 1
`define IRQ_MARKER_CLR 2
`define IRQ_BAD_KEY 3
`define IRQ_BITS 4
`endif

// ==== rtl/param_store_pkg.sv ====
// Types shared by the parameter store and restore control block.
// Assumes the constants header sits beside it.
`default_nettype none
`include "param_store_consts.svh"
package param_store_pkg;
   typedef struct packed {
      logic [23:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
   typedef struct packed {
      logic req;
      logic [`CAT_COUNT-1:0] cat_mask;
      logic with_marker;
   } save_cmd_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_REQ = 2'b01,
      ST_WAIT = 2'b11,
      ST_DONE = 2'b10
   } save_state_t;
endpackage
`default_nettype wire

// ==== rtl/parameter_store_restore_control.sv ====
// Store, discard and reboot command entries with the configuration marker.
// Assumes a nonvolatile engine on the same clock that answers each save request
// with a one-cycle done pulse, and parameter logic that pulses on savable writes.
// Functional notes
// - Save key written to store subindex starts saving that category.
// - Finished save replaces the store subindex value with 1.
// - Subindex 01 all, 02..06 single categories, 0B serial-bus settings.
// - Discard key written to discard subindex marks that category discarded.
// - Discarding leaves values in use untouched; effect only after restart.
// - Reboot key written to reboot subindex 01 restarts the device.
// - Discard via 01 covers all but tuning; tuning only via 06.
// - Savable writes clear markers, except store subindex 01 and marker writes.
// - Marker accepts date and time and is saved with save-all.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "param_store_consts.svh"
module parameter_store_restore_control
   import param_store_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire reg_req_t reg_req_in,
   input wire logic nv_done_in,
   input wire logic param_write_in,
   output var logic [31:0] rdata_out,
   output var save_cmd_t save_cmd_out,
   output var logic saving_out,
   output var logic [`CAT_COUNT-1:0] discarded_out,
   output var logic [31:0] marker_lo_out,
   output var logic [31:0] marker_hi_out,
   output var logic reboot_out,
   output var logic irq_out
);
   // Bit 3 flags a valid category subindex, bits 2:0 give its index.
   function automatic logic [3:0] cat_of(input logic [7:0] sub);
      logic [3:0] r;
      r = 4'h0;
      if (sub >= `SUB_ALL && sub <= `SUB_TUNING) begin
         r = {1'b1, 3'(sub - `SUB_ALL)};
      end else if (sub == `SUB_BUS) begin
         r = {1'b1, 3'(`CAT_COUNT - 1)};
      end
      return r;
   endfunction

   function automatic logic [2:0] first_one(input logic [`CAT_COUNT-1:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = `CAT_COUNT - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   logic [15:0] obj;
   logic [7:0] sub;
   logic [3:0] wcat;
   logic [2:0] cidx;
   logic store_wr, discard_wr, reboot_wr, save_key, discard_key, marker_clr;
   logic [31:0] store_reg [`CAT_COUNT];
   logic [31:0] discard_reg [`CAT_COUNT];
   logic [`CAT_COUNT-1:0] pending_reg;
   logic [31:0] reboot_reg;
   logic [`IRQ_BITS-1:0] status_reg, enable_reg, status_next, events;
   save_state_t state_reg;
   logic [2:0] cur_idx_reg;

   assign obj = reg_req_in.addr[23:8];
   assign sub = reg_req_in.addr[7:0];
   assign wcat = cat_of(sub);
   assign cidx = wcat[2:0];
   assign store_wr = reg_req_in.wr && obj == `OBJ_STORE && wcat[3];
   assign discard_wr = reg_req_in.wr && obj == `OBJ_DISCARD && wcat[3];
   assign reboot_wr = reg_req_in.wr && obj == `OBJ_REBOOT && sub == `SUB_ALL;
   assign save_key = store_wr && reg_req_in.wdata == `KEY_SAVE;
   assign discard_key = discard_wr && reg_req_in.wdata == `KEY_DISCARD;
   // marker clear sources
   // The reboot entry is itself a savable setting, so writing it counts.
   assign marker_clr = param_write_in
      || (reg_req_in.wr && obj == `OBJ_STORE && sub != `SUB_ALL)
      || (reg_req_in.wr && obj == `OBJ_REBOOT);

   genvar g;
   generate
      for (g = 0; g < `CAT_COUNT; g++) begin : g_cat
         always_ff @(posedge sys_clk_in or posedge rst_in) begin
            if (rst_in) begin
               store_reg[g] <= `ENTRY_RESET;
            end else if (store_wr && cidx == 3'(g)) begin
               store_reg[g] <= reg_req_in.wdata;
            end else if (state_reg == ST_DONE && cur_idx_reg == 3'(g)) begin
               store_reg[g] <= `SAVE_DONE_VALUE;
            end
         end
         always_ff @(posedge sys_clk_in or posedge rst_in) begin
            if (rst_in) begin
               pending_reg[g] <= 1'b0;
            end else if (save_key && cidx == 3'(g)) begin
               pending_reg[g] <= 1'b1;
            end else if (state_reg == ST_IDLE && first_one(pending_reg) == 3'(g)) begin
               pending_reg[g] <= 1'b0;
            end
         end
         always_ff @(posedge sys_clk_in or posedge rst_in) begin
            if (rst_in) begin
               discard_reg[g] <= `ENTRY_RESET;
            end else if (discard_wr && cidx == 3'(g)) begin
               discard_reg[g] <= reg_req_in.wdata;
            end
         end
         // only a flag for the next start; nothing in use is touched.
         always_ff @(posedge sys_clk_in or posedge rst_in) begin
            if (rst_in) begin
               discarded_out[g] <= 1'b0;
            end else if (discard_key && (cidx == 3'(g)
                  || (cidx == 3'h0 && g != `CAT_TUNING_IDX))) begin
               discarded_out[g] <= 1'b1;
            end else if (state_reg == ST_DONE && save_cmd_out.cat_mask[g]) begin
               discarded_out[g] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= ST_IDLE;
         cur_idx_reg <= 3'h0;
         save_cmd_out <= '0;
         saving_out <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (|pending_reg) begin
                  cur_idx_reg <= first_one(pending_reg);
                  save_cmd_out.req <= 1'b1;
                  save_cmd_out.with_marker <= first_one(pending_reg) == 3'h0;
                  save_cmd_out.cat_mask <= first_one(pending_reg) == 3'h0 ? `MASK_ALL
                     : 7'(7'h01 << first_one(pending_reg));
                  saving_out <= 1'b1;
                  state_reg <= ST_REQ;
               end
            end
            ST_REQ: begin
               save_cmd_out.req <= 1'b0;
               state_reg <= ST_WAIT;
            end
            ST_WAIT: begin
               if (nv_done_in) begin
                  state_reg <= ST_DONE;
               end
            end
            ST_DONE: begin
               // busy flag for the motor interlock
               saving_out <= |pending_reg;
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         marker_lo_out <= `ENTRY_RESET;
         marker_hi_out <= `ENTRY_RESET;
      end else if (marker_clr) begin
         marker_lo_out <= `ENTRY_RESET;
         marker_hi_out <= `ENTRY_RESET;
      end else if (reg_req_in.wr && obj == `OBJ_MARKER && sub == `SUB_ALL) begin
         marker_lo_out <= reg_req_in.wdata;
      end else if (reg_req_in.wr && obj == `OBJ_MARKER && sub == `SUB_MARKER_HI) begin
         marker_hi_out <= reg_req_in.wdata;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         reboot_reg <= `ENTRY_RESET;
         reboot_out <= 1'b0;
      end else begin
         reboot_out <= reboot_wr && reg_req_in.wdata == `KEY_REBOOT;
         if (reboot_wr) begin
            reboot_reg <= reg_req_in.wdata;
         end
      end
   end

   always_comb begin
      events = '0;
      events[`IRQ_SAVE_DONE] = state_reg == ST_DONE;
      events[`IRQ_DISCARD] = discard_key;
      events[`IRQ_MARKER_CLR] = marker_clr;
      events[`IRQ_BAD_KEY] = (store_wr && !save_key) || (discard_wr && !discard_key);
      status_next = status_reg | events;
      if (reg_req_in.wr && obj == `OBJ_IRQ_CLEAR) begin
         status_next = (status_reg & ~reg_req_in.wdata[`IRQ_BITS-1:0]) | events;
      end
   end

   // A new event in the clearing cycle survives the clear.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         status_reg <= '0;
         enable_reg <= '0;
         irq_out <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq_out <= |(status_next & enable_reg);
         if (reg_req_in.wr && obj == `OBJ_IRQ_ENABLE && sub == 8'h00) begin
            enable_reg <= reg_req_in.wdata[`IRQ_BITS-1:0];
         end
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= '0;
         if (reg_req_in.rd) begin
            if (obj == `OBJ_STORE && wcat[3]) begin
               rdata_out <= store_reg[cidx];
            end else if (obj == `OBJ_DISCARD && wcat[3]) begin
               rdata_out <= discard_reg[cidx];
            end else if (obj == `OBJ_MARKER && sub == `SUB_ALL) begin
               rdata_out <= marker_lo_out;
            end else if (obj == `OBJ_MARKER && sub == `SUB_MARKER_HI) begin
               rdata_out <= marker_hi_out;
            end else if (obj == `OBJ_REBOOT && sub == `SUB_ALL) begin
               rdata_out <= reboot_reg;
            end else if (obj == `OBJ_IRQ_STATUS && sub == 8'h00) begin
               rdata_out <= 32'(status_reg);
            end else if (obj == `OBJ_IRQ_ENABLE && sub == 8'h00) begin
               rdata_out <= 32'(enable_reg);
            end
         end
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   save_start_a: assert property (
      save_key && state_reg == ST_IDLE && pending_reg == '0 |-> ##2 save_cmd_out.req)
      else $error("Save key did not start a save.");
   done_one_a: assert property (
      state_reg == ST_DONE && !(store_wr && cidx == cur_idx_reg)
      |=> store_reg[$past(cur_idx_reg)] == `SAVE_DONE_VALUE)
      else $error("Finished save did not write 1.");
   bus_map_a: assert property (
      save_key && sub == `SUB_BUS && state_reg == ST_IDLE && pending_reg == '0
      |-> ##2 save_cmd_out.cat_mask == 7'h40)
      else $error("Serial-bus subindex saved the wrong category.");
   discard_set_a: assert property (
      discard_key |=> discarded_out[$past(cidx)])
      else $error("Discard key did not mark the category.");
   discard_keep_a: assert property (
      discard_wr && !marker_clr |=> $stable(marker_lo_out) && !reboot_out)
      else $error("Discard disturbed values in use.");
   reboot_key_a: assert property (
      reboot_wr |=> reboot_out == ($past(reg_req_in.wdata) == `KEY_REBOOT))
      else $error("Reboot pulse does not match the key.");
   tuning_kept_a: assert property (
      discard_key && cidx == 3'h0 && !discarded_out[`CAT_TUNING_IDX]
      |=> !discarded_out[`CAT_TUNING_IDX] && discarded_out[`CAT_COUNT-1])
      else $error("Discard-all touched tuning or missed a category.");
   marker_clr_a: assert property (
      param_write_in |=> marker_lo_out == '0 && marker_hi_out == '0)
      else $error("Savable write left the marker set.");
   marker_save_a: assert property (
      $rose(save_cmd_out.req) |-> save_cmd_out.with_marker
      == (save_cmd_out.cat_mask == `MASK_ALL))
      else $error("Marker not saved with save-all.");
   bad_key_a: assert property (
      store_wr && !save_key && state_reg == ST_IDLE && pending_reg == '0
      |-> ##2 !save_cmd_out.req)
      else $error("Wrong key started a save.");
   save_all_c: cover property (save_cmd_out.req && save_cmd_out.with_marker);
   discard_all_c: cover property (discard_key && cidx == 3'h0);
   reboot_c: cover property (reboot_out);
   irq_c: cover property (irq_out && status_reg[`IRQ_SAVE_DONE]);
endmodule
`default_nettype wire

// ==== testbench/nv_engine_model.sv ====
// Behavioural nonvolatile engine that answers each save request.
// Assumes the request pulse and this model share one clock.
`timescale 1ns/1ps
`default_nettype none
module nv_engine_model
   import param_store_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire save_cmd_t cmd_in,
   input wire logic [7:0] delay_in,
   output var logic done_out
);
   int cnt;
   // The delay is at least one, so done never falls in the request cycle.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt <= 0;
         done_out <= 1'b0;
      end else begin
         done_out <= (cnt == 1);
         if (cmd_in.req === 1'b1) begin
            cnt <= int'(delay_in) + 1;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== testbench/parameter_store_restore_control_bench.sv ====
// Self-checking bench for the parameter store and restore control block.
// Assumes the package, the constants header and the engine model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "param_store_consts.svh"
module parameter_store_restore_control_bench
   import param_store_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   reg_req_t req = '0;
   logic pw = 1'b0;
   logic [7:0] dly = 8'h03;
   logic nv_done, saving, boot, irq, req_mk;
   logic [31:0] rdata, mlo, mhi, v, mv, bad;
   save_cmd_t cmd;
   logic [6:0] disc, req_mask;
   logic [6:0] disc_m = '0;
   logic [7:0] subs [6] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, `SUB_BUS};
   int n_mismatch = 0;
   int comparisons = 0;
   int n_req = 0;
   int n_boot = 0;
   int n0;
   parameter_store_restore_control dut_u (.sys_clk_in(clk), .rst_in(rst),
      .reg_req_in(req), .nv_done_in(nv_done), .param_write_in(pw), .rdata_out(rdata),
      .save_cmd_out(cmd), .saving_out(saving), .discarded_out(disc),
      .marker_lo_out(mlo), .marker_hi_out(mhi), .reboot_out(boot), .irq_out(irq));
   nv_engine_model nv_u (.clk_in(clk), .rst_in(rst), .cmd_in(cmd), .delay_in(dly),
      .done_out(nv_done));
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (cmd.req === 1'b1) begin
         n_req++;
         req_mask = cmd.cat_mask;
         req_mk = cmd.with_marker;
      end
      if (boot === 1'b1) n_boot++;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [23:0] a, input logic [31:0] d);
      @(posedge clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clk);
      req.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [23:0] a, output logic [31:0] d);
      @(posedge clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask
   // master waits for completion by polling.
   task automatic save(input logic [7:0] s, input logic [6:0] m, input logic mk);
      int i;
      n0 = n_req;
      v = 32'h0;
      wr({`OBJ_STORE, s}, `KEY_SAVE);
      rd({`OBJ_STORE, s}, v);
      chk("saving busy", 32'h1, 32'(saving));
      for (i = 0; i < 60 && v !== `SAVE_DONE_VALUE; i++) rd({`OBJ_STORE, s}, v);
      chk("saving idle", 32'h0, 32'(saving));
      chk("store done", `SAVE_DONE_VALUE, v);
      chk("save reqs", 32'(n0 + 1), 32'(n_req));
      chk("save mask", 32'(m), 32'(req_mask));
      chk("with marker", 32'(mk), 32'(req_mk));
      disc_m = disc_m & ~m;
      chk("discarded", 32'(disc_m), 32'(disc));
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end
   initial begin
      void'($urandom(39));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd({`OBJ_STORE, `SUB_ALL}, v);
      chk("reset store", `ENTRY_RESET, v);
      rd(24'h300000, v);
      chk("unmapped read", 32'h0, v);
      $display("test reset finished");
      // stamp the marker, then save every category except tuning with it.
      mv = $urandom;
      wr({`OBJ_MARKER, `SUB_ALL}, mv);
      wr({`OBJ_MARKER, `SUB_MARKER_HI}, ~mv);
      save(`SUB_ALL, `MASK_ALL, 1'b1);
      chk("marker lo", mv, mlo);
      chk("marker hi", ~mv, mhi);
      rd({`OBJ_MARKER, `SUB_ALL}, v);
      chk("marker read", mv, v);
      $display("test save all finished");
      foreach (subs[k]) begin
         dly <= 8'($urandom_range(20, 1));
         save(subs[k], 7'(1 << (k + 1)), 1'b0);
      end
      chk("marker cleared", 32'h0, mlo);
      $display("test single saves finished");
      wr({`OBJ_MARKER, `SUB_ALL}, mv);
      chk("marker kept", mv, mlo);
      @(posedge clk);
      pw <= 1'b1;
      @(posedge clk);
      pw <= 1'b0;
      wait_n(2);
      rd({`OBJ_MARKER, `SUB_ALL}, v);
      chk("marker param", 32'h0, v);
      $display("test marker finished");
      wr({`OBJ_IRQ_CLEAR, 8'h00}, 32'h0000000F);
      wr({`OBJ_IRQ_ENABLE, 8'h00}, 32'h00000002);
      n0 = n_req;
      wr({`OBJ_DISCARD, `SUB_ALL}, `KEY_DISCARD);
      wait_n(3);
      disc_m = `MASK_ALL;
      chk("discard all", 32'(disc_m), 32'(disc));
      chk("no save", 32'(n0), 32'(n_req));
      chk("irq raised", 32'h1, 32'(irq));
      wr({`OBJ_DISCARD, `SUB_TUNING}, `KEY_DISCARD);
      wait_n(3);
      disc_m = disc_m | 7'h20;
      chk("discard tuning", 32'(disc_m), 32'(disc));
      wr({`OBJ_IRQ_ENABLE, 8'h00}, 32'h0);
      wait_n(2);
      chk("irq masked", 32'h0, 32'(irq));
      wr({`OBJ_IRQ_ENABLE, 8'h00}, 32'h00000002);
      wait_n(2);
      chk("irq again", 32'h1, 32'(irq));
      wr({`OBJ_IRQ_CLEAR, 8'h00}, 32'h00000002);
      wait_n(2);
      chk("irq cleared", 32'h0, 32'(irq));
      wr({`OBJ_IRQ_ENABLE, 8'h00}, 32'h00000001);
      rd({`OBJ_IRQ_ENABLE, 8'h00}, v);
      chk("irq enable", 32'h1, v);
      save(8'h04, 7'h08, 1'b0);
      chk("irq save done", 32'h1, 32'(irq));
      $display("test discard finished");
      n0 = n_req;
      bad = $urandom | 32'h80000000;
      wr({`OBJ_STORE, 8'h03}, bad);
      wr({`OBJ_DISCARD, 8'h02}, bad);
      wait_n(5);
      chk("bad key save", 32'(n0), 32'(n_req));
      chk("bad key discard", 32'(disc_m), 32'(disc));
      rd({`OBJ_STORE, 8'h03}, v);
      chk("bad key stored", bad, v);
      rd({`OBJ_DISCARD, 8'h02}, v);
      chk("bad discard stored", bad, v);
      rd({`OBJ_IRQ_STATUS, 8'h00}, v);
      chk("bad key status", 32'h1, 32'(v[`IRQ_BAD_KEY]));
      $display("test wrong keys finished");
      n0 = n_boot;
      wr({`OBJ_REBOOT, `SUB_ALL}, bad);
      wait_n(3);
      chk("boot refused", 32'(n0), 32'(n_boot));
      wr({`OBJ_REBOOT, `SUB_ALL}, `KEY_REBOOT);
      wait_n(3);
      chk("boot pulse", 32'(n0 + 1), 32'(n_boot));
      rd({`OBJ_REBOOT, `SUB_ALL}, v);
      chk("reboot entry", `KEY_REBOOT, v);
      $display("test restart finished");
      complete_run();
   end
endmodule
`default_nettype wire
